// ---- hw/csi_div.sv ----
// Bit clock divider that pulses once per expired count.
`default_nettype none

module csi_div
    import csi_pkg::*;
#(
    parameter int W = 12
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic run,
    input wire logic [W-1:0] divisor,
    output logic tick
);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic tick;
    } csi_div_s;

    csi_div_s q, d;

    // ****************************************
    // Count up to the divisor, then reload.
    // ****************************************
    // A stopped divider sits at zero so the next start gives a full half period.
    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (!run) begin
            d.cnt = '0;
        end else if (q.cnt == divisor) begin
            d.cnt = '0;
            d.tick = 1'b1; // Half period of the bit clock has passed.
        end else begin
            d.cnt = q.cnt + 1'b1;
        end
    end

    // State register.
    always_ff @(posedge clock) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick = q.tick;

endmodule

`default_nettype wire

// ---- hw/csi_pkg.sv ----
// Shared constants and types of the codec serial interface.
`default_nettype none

package csi_pkg;

    // ****************************************
    // Register byte offsets.
    // ****************************************
    localparam logic [7:0] CSI_OFF_CTRL = 8'h00;
    localparam logic [7:0] CSI_OFF_FRAME = 8'h04;
    localparam logic [7:0] CSI_OFF_CLKDIV = 8'h08;
    localparam logic [7:0] CSI_OFF_STATUS = 8'h0C;
    localparam logic [7:0] CSI_OFF_TXDATA = 8'h10;
    localparam logic [7:0] CSI_OFF_RXDATA = 8'h14;

    // ****************************************
    // Field positions.
    // ****************************************
    localparam int CSI_CTRL_EN_BIT = 0;
    localparam int CSI_CTRL_FMT_LSB = 1;
    localparam int CSI_CTRL_SDIR_BIT = 3;
    localparam int CSI_CTRL_CDIR_BIT = 4;
    localparam int CSI_FRAME_WL_LSB = 0;
    localparam int CSI_FRAME_FW_LSB = 4;
    localparam int CSI_STAT_RXF_BIT = 0;
    localparam int CSI_STAT_RUN_BIT = 1;
    localparam int CSI_STAT_BCLK_BIT = 2;
    localparam int CSI_STAT_FS_BIT = 3;
    localparam int CSI_STAT_BIT_LSB = 4;
    localparam int CSI_STAT_WORD_LSB = 8;

    // ****************************************
    // Reset values and fixed link figures.
    // ****************************************
    localparam logic [3:0] CSI_WL_RST = 4'hF;
    localparam logic [3:0] CSI_FW_RST = 4'h0;
    localparam logic [11:0] CSI_DIV_RST = 12'h000;
    localparam logic [3:0] CSI_AC_WL = 4'hF;
    localparam logic [3:0] CSI_AC_FW = 4'hF;
    localparam logic [7:0] CSI_AC_SYNC_BITS = 8'h10;
    localparam logic [1:0] CSI_RESP_OKAY = 2'h0;
    localparam logic [1:0] CSI_RESP_SLVERR = 2'h2;

    // Frame sync formats in register encoding order.
    typedef enum logic [1:0] {
        CSI_FMT_MULTI,
        CSI_FMT_I2S,
        CSI_FMT_AC16,
        CSI_FMT_AC20
    } csi_fmt_e;

endpackage

`default_nettype wire

// ---- hw/csi_top.sv ----
// Codec serial interface with an AXI4-Lite register port.
//
// The AXI4-Lite slave port and the register addresses were decided locally.
`default_nettype none

//
// Contract
// R1 - Disable resets all counters to initial state
// R2 - Internal clocks stop while disabled; the divider here runs whenever divisor is nonzero and direction is zero
// R3 - Enabled port owns its four pins
// R4 - Running divider may drive bit clock alone
// R5 - Word length field holds length minus one
// R6 - AC-Link modes ignore word length field
// R7 - Frame counter advances on word wrap
// R8 - AC-Link frame fixed at 256 bit clocks
// R9 - Two-bit field selects four sync formats
// R10 - Sync direction bit selects master or slave
// R11 - Frame sync starts serial data transfers
// R12 - Master starts sync when frame wraps
// R13 - Multi-channel sync is one-bit high pulse
// R14 - AC-Link sync high 16, low 240
// R15 - I2S sync has 50 percent duty
// R16 - Slave codec drives the frame sync
// R17 - Zero divisor stops the bit clock generator
// R18 - Bit rate is clock over 2(div+1)
// R19 - External clock: divisor zero, direction one
// R20 - Divisor ignored with external bit clock
// R21 - Bit clock toggles on each expiry
module csi_top
    import csi_pkg::*;
#(
    parameter int DIV_W = 12
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic codec_bit_clock_in,
    output logic codec_bit_clock_out,
    output logic codec_bit_clock_oe_n,
    input wire logic frame_sync_pin_in,
    output logic frame_sync_pin_out,
    output logic frame_sync_pin_oe_n,
    input wire logic serial_in_pin,
    output logic serial_out_pin_out,
    output logic serial_out_pin_oe_n
);

    typedef struct packed {
        // Control fields.
        logic port_on;
        csi_fmt_e fmt;
        logic sync_direction;
        logic bit_clock_direction;
        logic [3:0] word_len_minus_one;
        logic [3:0] frame_words_minus_one;
        logic [DIV_W-1:0] bit_clock_divisor;
        logic [15:0] tx_word;
        logic [15:0] rx_word;
        logic rx_full;
        // Bus slave.
        logic aw_got;
        logic w_got;
        logic [7:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        // Link side.
        logic sck;
        logic bc_prev;
        logic fs_prev;
        logic running;
        logic [3:0] bit_cnt;
        logic [3:0] word_cnt;
        logic [7:0] frame_pos;
        logic [15:0] tx_shift;
        logic [15:0] rx_shift;
        logic sdo;
        logic fs_out;
        logic bc_oe_n;
        logic fs_oe_n;
        logic sdo_oe_n;
    } csi_top_s;

    csi_top_s q, d;
    logic div_tick;
    logic div_run;

    // ****************************************
    // Bit clock divider.
    // ****************************************
    // R20 divisor ignored externally
    assign div_run = (q.bit_clock_divisor != '0) && !q.bit_clock_direction;

    // R17 R18 divider sets rate
    csi_div #(
        .W(DIV_W)
    ) u_div (
        .clock(clock),
        .rst(rst),
        .run(div_run),
        .divisor(q.bit_clock_divisor),
        .tick(div_tick)
    );

    // ****************************************
    // Register read mux.
    // ****************************************
    // Reading never disturbs the link; only the flag clear is a side effect.
    function automatic logic [31:0] rd_mux(input csi_top_s s, input logic [7:0] a);
        logic [31:0] v;
        v = '0;
        case (a)
            CSI_OFF_CTRL: begin
                v[CSI_CTRL_EN_BIT] = s.port_on;
                v[CSI_CTRL_FMT_LSB +: 2] = s.fmt;
                v[CSI_CTRL_SDIR_BIT] = s.sync_direction;
                v[CSI_CTRL_CDIR_BIT] = s.bit_clock_direction;
            end
            CSI_OFF_FRAME: begin
                v[CSI_FRAME_WL_LSB +: 4] = s.word_len_minus_one;
                v[CSI_FRAME_FW_LSB +: 4] = s.frame_words_minus_one;
            end
            CSI_OFF_CLKDIV: v[DIV_W-1:0] = s.bit_clock_divisor;
            CSI_OFF_STATUS: begin
                v[CSI_STAT_RXF_BIT] = s.rx_full;
                v[CSI_STAT_RUN_BIT] = s.running;
                v[CSI_STAT_BCLK_BIT] = s.bc_prev;
                v[CSI_STAT_FS_BIT] = s.fs_prev;
                v[CSI_STAT_BIT_LSB +: 4] = s.bit_cnt;
                v[CSI_STAT_WORD_LSB +: 4] = s.word_cnt;
            end
            CSI_OFF_TXDATA: v[15:0] = s.tx_word;
            CSI_OFF_RXDATA: v[15:0] = s.rx_word;
            default: v = '0;
        endcase
        return v;
    endfunction

    // Address check shared by both channels.
    function automatic logic mapped(input logic [7:0] a);
        return (a == CSI_OFF_CTRL) || (a == CSI_OFF_FRAME) || (a == CSI_OFF_CLKDIV)
            || (a == CSI_OFF_STATUS) || (a == CSI_OFF_TXDATA) || (a == CSI_OFF_RXDATA);
    endfunction

    // ****************************************
    // Next state.
    // ****************************************
    always_comb begin
        logic ac;
        logic [3:0] wl;
        logic [3:0] fw;
        logic bc_now;
        logic fall;
        logic rise;
        logic sync_ev;
        logic start;
        logic [8:0] flen;
        logic [15:0] tx_al;
        logic [15:0] rx_mask;
        logic [15:0] rx_new;
        ac = 1'b0;
        wl = '0;
        fw = '0;
        bc_now = 1'b0;
        fall = 1'b0;
        rise = 1'b0;
        sync_ev = 1'b0;
        start = 1'b0;
        flen = '0;
        tx_al = '0;
        rx_mask = '0;
        rx_new = '0;
        d = q;

        // Write address and data are taken independently, in either order.
        if (s_axi_awvalid && q.awready) begin
            d.aw_got = 1'b1;
            d.waddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready) begin
            d.w_got = 1'b1;
            d.wdata = s_axi_wdata;
            d.wstrb = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end

        // Both halves held: apply byte lanes and answer.
        if (q.aw_got && q.w_got && !q.bvalid) begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = mapped(q.waddr) ? CSI_RESP_OKAY : CSI_RESP_SLVERR;
            case (q.waddr)
                CSI_OFF_CTRL: begin
                    if (q.wstrb[0]) begin
                        d.port_on = q.wdata[CSI_CTRL_EN_BIT];
                        // R9 format select
                        d.fmt = csi_fmt_e'(q.wdata[CSI_CTRL_FMT_LSB +: 2]);
                        // R10 master or slave
                        d.sync_direction = q.wdata[CSI_CTRL_SDIR_BIT];
                        d.bit_clock_direction = q.wdata[CSI_CTRL_CDIR_BIT];
                    end
                end
                CSI_OFF_FRAME: begin
                    if (q.wstrb[0]) begin
                        d.word_len_minus_one = q.wdata[CSI_FRAME_WL_LSB +: 4];
                        d.frame_words_minus_one = q.wdata[CSI_FRAME_FW_LSB +: 4];
                    end
                end
                CSI_OFF_CLKDIV: begin
                    if (q.wstrb[0]) begin
                        d.bit_clock_divisor[7:0] = q.wdata[7:0];
                    end
                    if (q.wstrb[1]) begin
                        d.bit_clock_divisor[DIV_W-1:8] = q.wdata[DIV_W-1:8];
                    end
                end
                CSI_OFF_TXDATA: begin
                    if (q.wstrb[0]) begin
                        d.tx_word[7:0] = q.wdata[7:0];
                    end
                    if (q.wstrb[1]) begin
                        d.tx_word[15:8] = q.wdata[15:8];
                    end
                end
                default: ;
            endcase
        end
        d.awready = !d.aw_got && !d.bvalid;
        d.wready = !d.w_got && !d.bvalid;

        // Read channel: one read outstanding, data held until rready.
        if (s_axi_arvalid && q.arready) begin
            d.arready = 1'b0;
            d.rvalid = 1'b1;
            d.rdata = rd_mux(q, s_axi_araddr);
            d.rresp = mapped(s_axi_araddr) ? CSI_RESP_OKAY : CSI_RESP_SLVERR;
            if (s_axi_araddr == CSI_OFF_RXDATA) begin
                d.rx_full = 1'b0;
            end
        end
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
            d.arready = 1'b1;
        end

        // R21 toggle on expiry
        if (!div_run) begin
            d.sck = 1'b0;
        end else if (div_tick) begin
            d.sck = !q.sck;
        end

        // R6 R8 fixed AC-Link slots
        ac = (q.fmt == CSI_FMT_AC16) || (q.fmt == CSI_FMT_AC20);
        wl = ac ? CSI_AC_WL : q.word_len_minus_one;
        fw = ac ? CSI_AC_FW : q.frame_words_minus_one;
        flen = (9'(wl) + 9'd1) * (9'(fw) + 9'd1);

        // R20 pick bit clock source
        bc_now = q.bit_clock_direction ? codec_bit_clock_in : q.sck;
        fall = q.bc_prev && !bc_now;
        rise = !q.bc_prev && bc_now;
        d.bc_prev = bc_now;

        // R16 slave sync edge
        if (q.fmt == CSI_FMT_I2S) begin
            sync_ev = frame_sync_pin_in != q.fs_prev;
        end else begin
            sync_ev = frame_sync_pin_in && !q.fs_prev;
        end

        if (!q.port_on) begin
            // R1 R2 disabled means reset
            d.running = 1'b0;
            d.bit_cnt = '0;
            d.word_cnt = '0;
            d.frame_pos = '0;
            d.tx_shift = '0;
            d.rx_shift = '0;
            d.sdo = 1'b0;
            d.fs_out = 1'b0;
            d.fs_prev = 1'b0;
        end else if (fall) begin
            d.fs_prev = frame_sync_pin_in;
            // R12 new frame at wrap
            if (!q.sync_direction) begin
                start = !q.running || ((q.bit_cnt == wl) && (q.word_cnt == fw));
            end else begin
                start = sync_ev;
            end
            if (start) begin
                d.running = 1'b1;
                d.bit_cnt = '0;
                d.word_cnt = '0;
                d.frame_pos = '0;
            end else if (q.running) begin
                d.frame_pos = q.frame_pos + 1'b1;
                // R5 R7 word and frame counters
                if (q.bit_cnt == wl) begin
                    d.bit_cnt = '0;
                    d.word_cnt = (q.word_cnt == fw) ? 4'h0 : q.word_cnt + 1'b1;
                end else begin
                    d.bit_cnt = q.bit_cnt + 1'b1;
                end
            end
            // R11 data follows frame
            if (d.running && (d.bit_cnt == '0)) begin
                tx_al = q.tx_word << (4'hF - wl);
                d.sdo = tx_al[15];
                d.tx_shift = tx_al << 1;
            end else begin
                d.sdo = q.tx_shift[15];
                d.tx_shift = q.tx_shift << 1;
            end
            // Master sync shape per format.
            case (q.fmt)
                // R13 one-bit pulse
                CSI_FMT_MULTI: d.fs_out = d.running && (d.frame_pos == '0);
                // R15 half frame each
                CSI_FMT_I2S: d.fs_out = {1'b0, d.frame_pos} >= (flen >> 1);
                // R14 16 high, 240 low
                CSI_FMT_AC16: d.fs_out = d.frame_pos < CSI_AC_SYNC_BITS;
                CSI_FMT_AC20: d.fs_out = d.frame_pos < CSI_AC_SYNC_BITS;
                default: d.fs_out = 1'b0;
            endcase
        end else if (rise && q.running) begin
            // Sample serial input; the last bit of a word completes it.
            rx_new = {q.rx_shift[14:0], serial_in_pin};
            d.rx_shift = rx_new;
            if (q.bit_cnt == wl) begin
                rx_mask = 16'hFFFF >> (4'hF - wl);
                d.rx_word = rx_new & rx_mask;
                d.rx_full = 1'b1; // Set wins over a same-cycle read clear.
            end
        end

        // R3 R4 pin ownership
        d.bc_oe_n = !((q.port_on || div_run) && !q.bit_clock_direction);
        d.fs_oe_n = !(q.port_on && !q.sync_direction);
        d.sdo_oe_n = !q.port_on;
    end

    // ****************************************
    // State register.
    // ****************************************
    always_ff @(posedge clock) begin
        if (rst) begin
            q <= '0;
            q.fmt <= CSI_FMT_MULTI;
            q.word_len_minus_one <= CSI_WL_RST;
            q.frame_words_minus_one <= CSI_FW_RST;
            q.bit_clock_divisor <= DIV_W'(CSI_DIV_RST);
            q.bresp <= CSI_RESP_OKAY;
            q.rresp <= CSI_RESP_OKAY;
            q.arready <= 1'b1; // A read may be offered from the first cycle on.
            q.bc_oe_n <= 1'b1;
            q.fs_oe_n <= 1'b1;
            q.sdo_oe_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ****************************************
    // Outputs, all straight from the state register.
    // ****************************************
    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bresp = q.bresp;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_arready = q.arready;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign s_axi_rvalid = q.rvalid;
    assign codec_bit_clock_out = q.sck;
    assign codec_bit_clock_oe_n = q.bc_oe_n;
    assign frame_sync_pin_out = q.fs_out;
    assign frame_sync_pin_oe_n = q.fs_oe_n;
    assign serial_out_pin_out = q.sdo;
    assign serial_out_pin_oe_n = q.sdo_oe_n;

endmodule

`default_nettype wire

// ---- tb/codec_serial_interface_test.sv ----
// Self-checking bench of the codec serial interface.
`default_nettype none

module codec_serial_interface_test
    import csi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, rst = 1;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic codec_bit_clock_out, codec_bit_clock_oe_n, frame_sync_pin_out, frame_sync_pin_oe_n;
    logic serial_out_pin_out, serial_out_pin_oe_n, sdi, ext_bclk, ext_fs, ext_on = 0;
    logic [15:0] word = 16'h000A;
    int failures = 0, cmp_count = 0;
    int exp_hi[4] = '{4, 16, 64, 64};
    int exp_lo[4] = '{28, 16, 960, 960};
    // Pin levels: whoever drives wins.
    wire logic bclk_w = codec_bit_clock_oe_n ? ext_bclk : codec_bit_clock_out;
    wire logic fs_w = frame_sync_pin_oe_n ? ext_fs : frame_sync_pin_out;

    csi_top u_csi_top (.*, .codec_bit_clock_in(bclk_w), .frame_sync_pin_in(fs_w),
        .serial_in_pin(sdi));
    csi_codec_model u_csi_codec_model (.*, .bclk(bclk_w), .fsync(fs_w), .wl(4'h3));

    // ****
    // Tasks
    // ****
    always #5 clock = ~clock;

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Address and data go out together; each drops once taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ad, wd;
        ad = 0;
        wd = 0;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge clock);
            if (!ad && s_axi_awready === 1'b1) begin
                ad = 1;
                s_axi_awvalid <= 0;
            end
            if (!wd && s_axi_wready === 1'b1) begin
                wd = 1;
                s_axi_wvalid <= 0;
            end
        end while (!(ad && wd));
        do @(posedge clock); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 0;
        chk("bresp", 32'(er), 32'(s_axi_bresp));
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do @(posedge clock); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 0;
        do @(posedge clock); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 0;
        d = s_axi_rdata;
        chk("rresp", 32'(er), 32'(s_axi_rresp));
    endtask

    // Clocks high then low of the bit clock (0) or sync pin (1).
    task automatic span(input bit sel, output int hi, output int lo);
        hi = 0;
        lo = 0;
        while ((sel ? frame_sync_pin_out : codec_bit_clock_out) !== 1'b0) @(posedge clock);
        while ((sel ? frame_sync_pin_out : codec_bit_clock_out) !== 1'b1) @(posedge clock);
        while ((sel ? frame_sync_pin_out : codec_bit_clock_out) === 1'b1) begin
            hi++;
            @(posedge clock);
        end
        while ((sel ? frame_sync_pin_out : codec_bit_clock_out) === 1'b0) begin
            lo++;
            @(posedge clock);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ****
    // Tests
    // ****
    initial begin
        logic [31:0] d;
        int hi, lo, n;
        repeat (10) @(posedge clock);
        rst <= 0;
        @(posedge clock);
        chk("oe_reset", 32'h0000_0007, 32'({codec_bit_clock_oe_n, frame_sync_pin_oe_n,
            serial_out_pin_oe_n}));
        rd(CSI_OFF_FRAME, d, CSI_RESP_OKAY);
        chk("frame_reset", 32'h0000_000F, d);
        wr(CSI_OFF_CLKDIV, 32'h0000_0002, CSI_RESP_OKAY);
        span(0, hi, lo);
        chk("bclk_hi", 3, hi);
        chk("bclk_lo", 3, lo);
        chk("oe_alone", 32'h0000_0003, 32'({codec_bit_clock_oe_n, frame_sync_pin_oe_n,
            serial_out_pin_oe_n}));
        wr(CSI_OFF_CLKDIV, 32'h0000_0000, CSI_RESP_OKAY);
        repeat (4) @(posedge clock);
        d[0] = codec_bit_clock_out;
        n = 0;
        repeat (16) begin
            @(posedge clock);
            if (codec_bit_clock_out !== d[0]) n++;
        end
        chk("bclk_moves", 0, n);
        wr(CSI_OFF_FRAME, 32'h0000_0013, CSI_RESP_OKAY);
        wr(CSI_OFF_TXDATA, 32'h0000_0006, CSI_RESP_OKAY);
        wr(CSI_OFF_CLKDIV, 32'h0000_0001, CSI_RESP_OKAY);
        // Each format as master; four-bit words, two words to a frame in multi-channel and I2S.
        for (int f = 0; f < 4; f++) begin
            wr(CSI_OFF_CTRL, 32'h0000_0000, CSI_RESP_OKAY);
            wr(CSI_OFF_CTRL, 32'(f * 2 + 1), CSI_RESP_OKAY);
            span(1, hi, lo);
            chk("sync_hi", exp_hi[f], hi);
            chk("sync_lo", exp_lo[f], lo);
            if (f == 0) begin
                n = 0;
                repeat (4) begin
                    n = n * 2 + serial_out_pin_out;
                    repeat (4) @(posedge clock);
                end
                chk("sdo_word", 32'h0000_0006, n);
                chk("sync_oe", 0, 32'(frame_sync_pin_oe_n));
                rd(CSI_OFF_RXDATA, d, CSI_RESP_OKAY);
                chk("rx_word", 32'h0000_000A, d);
            end
        end
        wr(CSI_OFF_CTRL, 32'h0000_0000, CSI_RESP_OKAY);
        rd(CSI_OFF_STATUS, d, CSI_RESP_OKAY);
        chk("oe_off", 32'h0000_0003, 32'({frame_sync_pin_oe_n, serial_out_pin_oe_n}));
        chk("counts_off", 0, 32'(d[11:4]));
        wr(8'h3C, 32'hFFFF_FFFF, CSI_RESP_SLVERR);
        rd(8'h3C, d, CSI_RESP_SLVERR);
        chk("unmapped", 0, d);
        // Slave with the codec's own clock; the divisor must not matter.
        word <= 16'h0005;
        ext_on <= 1;
        wr(CSI_OFF_CLKDIV, 32'h0000_0005, CSI_RESP_OKAY);
        wr(CSI_OFF_CTRL, 32'h0000_0019, CSI_RESP_OKAY);
        repeat (300) @(posedge clock);
        chk("oe_slave", 32'h0000_0003, 32'({codec_bit_clock_oe_n, frame_sync_pin_oe_n}));
        rd(CSI_OFF_RXDATA, d, CSI_RESP_OKAY);
        chk("rx_slave", 32'h0000_0005, d);
        ext_on <= 0;
        final_report();
    end

    // A hang counts as a mismatch.
    initial begin
        repeat (30000) @(posedge clock);
        failures++;
        final_report();
    end
endmodule

`default_nettype wire

// ---- tb/csi_checker_assertions.sv ----
// Port-level timing checks of the codec serial interface.
`default_nettype none

// ****
// Checker
// ****
module csi_checker
    import csi_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic codec_bit_clock_out,
    input wire logic codec_bit_clock_oe_n,
    input wire logic frame_sync_pin_out,
    input wire logic frame_sync_pin_oe_n,
    input wire logic serial_out_pin_out,
    input wire logic serial_out_pin_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    // Reset releases every pin.
    a_reset_quiet: assert property (disable iff (1'b0) rst |=> codec_bit_clock_oe_n
        && frame_sync_pin_oe_n && serial_out_pin_oe_n) else $error("pin driven in reset");
    // A half period lasts two clocks at least; writes may reload it.
    a_bclk_half: assert property (disable iff (rst || s_axi_wvalid || !s_axi_awready)
        $changed(codec_bit_clock_out) && !codec_bit_clock_oe_n |=>
        $stable(codec_bit_clock_out) || codec_bit_clock_oe_n) else $error("bit clock too fast");
    a_sync_on_fall: assert property (!frame_sync_pin_oe_n && !$past(frame_sync_pin_oe_n)
        && !codec_bit_clock_oe_n && $changed(frame_sync_pin_out) |-> !codec_bit_clock_out)
        else $error("sync moved off a falling edge");
    a_sdo_on_fall: assert property (!serial_out_pin_oe_n && !$past(serial_out_pin_oe_n)
        && !codec_bit_clock_oe_n && $changed(serial_out_pin_out) |-> !codec_bit_clock_out)
        else $error("data moved off a falling edge");
    a_sync_needs_on: assert property (!frame_sync_pin_oe_n |-> !serial_out_pin_oe_n)
        else $error("sync driven while port is off");
    a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
    a_one_resp: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answered twice");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read not answered");
    a_wr_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("second write taken early");

    c_sync_rise: cover property (!frame_sync_pin_oe_n && $rose(frame_sync_pin_out));
    c_bclk_alone: cover property (!codec_bit_clock_oe_n && frame_sync_pin_oe_n);
    c_slave: cover property (codec_bit_clock_oe_n && !serial_out_pin_oe_n);
endmodule

bind csi_top csi_checker u_csi_checker (.*);

`default_nettype wire

// ---- tb/csi_codec_model.sv ----
// Behavioural codec that faces the serial port.
`default_nettype none

module csi_codec_model
    import csi_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic bclk,
    input wire logic fsync,
    input wire logic ext_on,
    input wire logic [3:0] wl,
    input wire logic [15:0] word,
    output logic sdi,
    output logic ext_bclk,
    output logic ext_fs
);
    timeunit 1ns;
    timeprecision 1ps;
    logic bprev_q;
    logic [3:0] cnt_q;
    logic [1:0] div_q;

    // our clock runs only when asked, else stands low.
    always_ff @(posedge clock) begin
        if (rst || !ext_on) begin
            div_q <= 2'h0;
            ext_bclk <= 1'b0;
        end else begin
            div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
            if (div_q == 2'h2) ext_bclk <= !ext_bclk;
        end
    end

    // edges seen one clock late, like the port.
    always_ff @(posedge clock) begin
        bprev_q <= bclk;
        if (rst) begin
            cnt_q <= 4'h0;
            sdi <= 1'b0;
            ext_fs <= 1'b0;
        end else if (bprev_q && !bclk) begin
            sdi <= word[(cnt_q == 4'h0) ? 4'h0 : wl - cnt_q + 4'h1];
            ext_fs <= (cnt_q == 4'h0);
            cnt_q <= (cnt_q == wl) ? 4'h0 : cnt_q + 4'h1;
        end else if (!bprev_q && bclk && fsync && !ext_on) begin
            // The master sync marks the first bit, so realign our count.
            cnt_q <= 4'h2;
        end
    end
endmodule

`default_nettype wire
